// ==== hw/vpe_cap_req.sv ====
`timescale 1ns/1ps
// ************************************************************
// capture request engine for one fifo
// ************************************************************
module vpe_cap_req #(
  parameter int LVL_W = vpe_pkg::LVL_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic active,
  input wire vpe_pkg::vpe_cfg_s cfg,
  input wire logic [LVL_W-1:0] level,
  input wire logic dma_rd,
  output logic req,
  output logic outstanding
);
  localparam int TW = vpe_pkg::THR_W;
  localparam logic [TW-1:0] ONE = 1;
  logic pend_r, svc_r, req_r, gen_fld_r, pend_fld_r, svc_fld_r;
  logic [TW-1:0] cnt_r; // doublewords left in service
  logic [vpe_pkg::EVT_W-1:0] gen_cnt_r; // events left this field
  logic [TW-1:0] thr_gen, thr_pend, thr_svc;
  logic [LVL_W:0] need;
  logic over, raise, start;

  // field of the next request sets the level needed [R22] [R24]
  assign thr_gen = gen_fld_r ? cfg.thr2 : cfg.thr1;
  assign thr_pend = pend_fld_r ? cfg.thr2 : cfg.thr1;
  assign thr_svc = svc_fld_r ? cfg.thr2 : cfg.thr1;
  assign need = svc_r ? (LVL_W+1)'(thr_svc) + (LVL_W+1)'(thr_gen) : (LVL_W+1)'(thr_gen);
  assign over = svc_r ? ({1'b0, level} > need) : ({1'b0, level} >= need); // [R18]
  assign raise = active && !pend_r && over; // [R16] [R17]
  assign start = dma_rd && pend_r && !svc_r;

  // one pending request; first read starts its service
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pend_r <= 1'b0;
    else if (!active)
      pend_r <= 1'b0;
    else if (raise)
      pend_r <= 1'b1;
    else if (start)
      pend_r <= 1'b0; // [R17]
  end

  // field tag of the pending request
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pend_fld_r <= 1'b0;
    else if (raise)
      pend_fld_r <= gen_fld_r;
  end

  // transfer counter loads the serviced field's threshold
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      svc_r <= 1'b0;
      cnt_r <= '0;
      svc_fld_r <= 1'b0;
    end
    else if (!active)
      svc_r <= 1'b0;
    else if (start)
    begin
      cnt_r <= thr_pend - ONE; // [R19] [R23]
      svc_r <= thr_pend > ONE;
      svc_fld_r <= pend_fld_r;
    end
    else if (dma_rd && svc_r)
    begin
      cnt_r <= cnt_r - ONE; // [R19]
      svc_r <= cnt_r != ONE;
    end
  end

  // events-per-field counter picks the field
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gen_fld_r <= 1'b0;
      gen_cnt_r <= '0;
    end
    else if (!active)
    begin
      gen_fld_r <= 1'b0;
      gen_cnt_r <= cfg.ct1;
    end
    else if (raise)
    begin
      if (gen_cnt_r <= 1)
      begin
        gen_fld_r <= !gen_fld_r; // [R22]
        gen_cnt_r <= gen_fld_r ? cfg.ct1 : cfg.ct2;
      end
      else
        gen_cnt_r <= gen_cnt_r - 1'b1;
    end
  end

  // request pulse to the dma controller
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      req_r <= 1'b0;
    else
      req_r <= raise;
  end
  assign req = req_r;
  assign outstanding = pend_r;

  property p_one_out;
    @(posedge ref_clk) disable iff (sys_rst) (pend_r && !dma_rd) |=> !req;
  endproperty
  a_one_out: assert property (p_one_out) else $error("second request outstanding"); // [R17]
  property p_cnt_load;
    @(posedge ref_clk) disable iff (sys_rst)
      (active && start) |=> cnt_r == $past(thr_pend) - ONE;
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("counter load wrong"); // [R19]
  property p_raise_cause;
    @(posedge ref_clk) disable iff (sys_rst)
      req |-> $past(over) && $past(active) && pend_r;
  endproperty
  a_raise_cause: assert property (p_raise_cause) else $error("request without level"); // [R16]
endmodule

// ==== hw/vpe_irq_pulse.sv ====
`timescale 1ns/1ps
// ************************************************************
// single pulse when pending goes from none to some
// ************************************************************
module vpe_irq_pulse (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pending,
  input wire logic rearm,
  output logic irq_pulse
);
  logic armed_r; // next pending edge may pulse
  logic pulse_r;

  // arm state: consumed by a pulse, restored by idle or a clear
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      armed_r <= 1'b1;
    else if (armed_r && pending)
      armed_r <= 1'b0; // [R10]
    else if (rearm || !pending)
      armed_r <= 1'b1; // [R13]
  end

  // one clock pulse, no level kept
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pulse_r <= 1'b0;
    else
      pulse_r <= armed_r && pending; // [R9] [R25]
  end
  assign irq_pulse = pulse_r;

  property p_pulse_one;
    @(posedge ref_clk) disable iff (sys_rst) irq_pulse |=> !irq_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse wider than one cycle"); // [R25]
  property p_pulse_cause;
    @(posedge ref_clk) disable iff (sys_rst)
      irq_pulse |-> $past(armed_r) && $past(pending);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without cause"); // [R10]
  property p_no_repulse;
    @(posedge ref_clk) disable iff (sys_rst)
      (pending && !armed_r && !rearm) |=> !irq_pulse;
  endproperty
  a_no_repulse: assert property (p_no_repulse) else $error("pulse while disarmed"); // [R10]
endmodule

// ==== hw/vpe_pkg.sv ====
// ************************************************************
// video port event logic: shared constants and types
// ************************************************************
package vpe_pkg;
  // widths
  localparam int THR_W = 12; // threshold in doublewords
  localparam int EVT_W = 12; // events per field
  localparam int LVL_W = 13; // fifo fill level
  localparam int NFLAG = 12; // interrupt sources
  localparam int NFIFO = 6; // three fifos per channel
  localparam int AW = 8; // byte address width
  // register byte offsets
  localparam logic [AW-1:0] OFS_DCTL = 8'h00;
  localparam logic [AW-1:0] OFS_ISTAT = 8'h04;
  localparam logic [AW-1:0] OFS_IEN = 8'h08;
  localparam logic [AW-1:0] OFS_CTHR_A = 8'h0C;
  localparam logic [AW-1:0] OFS_CTHR_B = 8'h10;
  localparam logic [AW-1:0] OFS_EVT_A = 8'h14;
  localparam logic [AW-1:0] OFS_EVT_B = 8'h18;
  localparam logic [AW-1:0] OFS_CCTL = 8'h1C;
  localparam logic [AW-1:0] OFS_RSTAT = 8'h20;
  // field positions
  localparam int DCTL_EN_BIT = 0;
  localparam int DCTL_BLK_BIT = 1;
  localparam int DCTL_RST_BIT = 2;
  localparam int DCTL_MODE_LSB = 4;
  localparam int MODE_W = 4;
  localparam int IEN_GIE_BIT = 16;
  localparam int HI_LSB = 16; // second field value
  localparam int CCTL_SEP_LSB = 2; // three-fifo mode bits
  localparam int RSTAT_BUSY_BIT = 8;
  // reset values
  localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
  localparam logic BLK_RST = 1'b1;
  localparam logic [THR_W-1:0] THR_RST = 12'h001;
  localparam logic [EVT_W-1:0] EVT_RST = 12'h001;
  // channel clock edges seen before the display reset completes
  localparam int CRST_EDGES = 2;
  // per-fifo request configuration
  typedef struct packed {
    logic [THR_W-1:0] thr1;
    logic [THR_W-1:0] thr2;
    logic [EVT_W-1:0] ct1;
    logic [EVT_W-1:0] ct2;
  } vpe_cfg_s;
  // display channel reset sequence
  typedef enum logic [1:0] {DR_IDLE, DR_WAIT, DR_DONE} vpe_drst_e;
endpackage

// ==== hw/vpe_top.sv ====
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
// Operation
// R1 - channel reset bit resets display channel only
// R2 - during reset no requests, writes still acknowledged
// R3 - reset restores defaults, flushes fifo, clears enable
// R4 - reset bit self-clears after reset completes
// R5 - enabled: only enable, reset, blanking writable
// R6 - enabled display drives data and control outputs
// R7 - fifo output and requests wait for unblanking
// R8 - twelve status flags feed the interrupt
// R9 - interrupt output is a pulse only
// R10 - pulse only when set flags go none-to-some
// R11 - per-source enable and global enable gate
// R12 - write one clears status flag
// R13 - clearing a set flag rearms the pulse
// R14 - software reads, services, then clears flags
// R15 - six request outputs, three per channel
// R16 - raise request when level crosses threshold
// R17 - no new request until service starts
// R18 - over twice threshold allows next request
// R19 - transfer counter counts down read doublewords
// R20 - three fifos tracked independently in split modes
// R21 - chroma threshold is half of rounded-up threshold
// R22 - events-per-field counter selects field threshold
// R23 - counter loads serviced field's threshold
// R24 - field boundary uses summed thresholds
// R25 - interrupt pulse lasts one clock
module vpe_top #(
  parameter int LVL_W = vpe_pkg::LVL_W,
  parameter int CRST_EDGES = vpe_pkg::CRST_EDGES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [vpe_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [vpe_pkg::NFLAG-1:0] flag_set,
  output logic irq_pulse,
  input wire logic [vpe_pkg::NFIFO-1:0][LVL_W-1:0] cap_fifo_level,
  input wire logic [vpe_pkg::NFIFO-1:0] cap_dma_rd,
  output logic [vpe_pkg::NFIFO-1:0] cap_req,
  input wire logic channel_input_clock,
  output logic display_enable_bit,
  output logic display_blanking_bit,
  output logic [vpe_pkg::MODE_W-1:0] disp_mode,
  output logic disp_fifo_flush,
  output logic disp_count_run,
  output logic disp_out_drive,
  output logic disp_fifo_out_en,
  output logic disp_req_allow,
  output logic disp_wr_to_fifo
);
  // ************************************************************
  // register bus slave
  // ************************************************************
  logic ack_r; // answer cycle of a request
  logic [31:0] rdata_r; // registered read data
  logic [31:0] rd_img; // addressed register image
  logic [31:0] bmask; // byte-enable mask
  logic [31:0] wd_m; // masked write data
  logic [31:0] wr_val; // merged write value
  logic fire_wr; // write takes effect

  // one wait state on every access
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read || avs_write) && !ack_r;
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign fire_wr = avs_write && ack_r;
  assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd_m = avs_writedata & bmask;
  assign wr_val = (rd_img & ~bmask) | wd_m;

  // read data captured in the wait cycle
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_r <= '0;
    else if (avs_read && !ack_r)
      rdata_r <= rd_img;
  end
  assign avs_readdata = rdata_r;

  // ************************************************************
  // registers
  // ************************************************************
  logic dctl_en_r, dctl_blk_r, dctl_rst_r;
  logic [vpe_pkg::MODE_W-1:0] dctl_mode_r; // locked while enabled
  logic [vpe_pkg::NFLAG-1:0] istat_r, ien_r, clr;
  logic gie_r; // global interrupt enable
  logic [1:0][vpe_pkg::THR_W-1:0] thr1_r, thr2_r;
  logic [1:0][vpe_pkg::EVT_W-1:0] ct1_r, ct2_r;
  logic [1:0] cap_en_r, cap_sep_r;
  logic [vpe_pkg::NFIFO-1:0] busy;
  vpe_pkg::vpe_drst_e drst_r;
  logic rst_done;
  logic wr_dctl, wr_istat;

  assign wr_dctl = fire_wr && avs_address == vpe_pkg::OFS_DCTL;
  assign wr_istat = fire_wr && avs_address == vpe_pkg::OFS_ISTAT;
  assign rst_done = drst_r == vpe_pkg::DR_DONE;

  // read multiplexer; unmapped reads return zero
  always_comb
  begin
    rd_img = '0;
    case (avs_address)
      vpe_pkg::OFS_DCTL:
      begin
        rd_img[vpe_pkg::DCTL_EN_BIT] = dctl_en_r;
        rd_img[vpe_pkg::DCTL_BLK_BIT] = dctl_blk_r;
        rd_img[vpe_pkg::DCTL_RST_BIT] = dctl_rst_r;
        rd_img[vpe_pkg::DCTL_MODE_LSB +: vpe_pkg::MODE_W] = dctl_mode_r;
      end
      vpe_pkg::OFS_ISTAT: rd_img[vpe_pkg::NFLAG-1:0] = istat_r;
      vpe_pkg::OFS_IEN:
      begin
        rd_img[vpe_pkg::NFLAG-1:0] = ien_r;
        rd_img[vpe_pkg::IEN_GIE_BIT] = gie_r;
      end
      vpe_pkg::OFS_CTHR_A, vpe_pkg::OFS_CTHR_B:
      begin
        rd_img[vpe_pkg::THR_W-1:0] = thr1_r[avs_address[4]];
        rd_img[vpe_pkg::HI_LSB +: vpe_pkg::THR_W] = thr2_r[avs_address[4]];
      end
      vpe_pkg::OFS_EVT_A, vpe_pkg::OFS_EVT_B:
      begin
        rd_img[vpe_pkg::EVT_W-1:0] = ct1_r[avs_address[3]];
        rd_img[vpe_pkg::HI_LSB +: vpe_pkg::EVT_W] = ct2_r[avs_address[3]];
      end
      vpe_pkg::OFS_CCTL:
      begin
        rd_img[1:0] = cap_en_r;
        rd_img[vpe_pkg::CCTL_SEP_LSB +: 2] = cap_sep_r;
      end
      vpe_pkg::OFS_RSTAT:
      begin
        rd_img[vpe_pkg::NFIFO-1:0] = busy;
        rd_img[vpe_pkg::RSTAT_BUSY_BIT] = dctl_rst_r;
      end
      default: rd_img = '0;
    endcase
  end

  // display control; reset completion restores defaults
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dctl_en_r <= 1'b0;
      dctl_blk_r <= vpe_pkg::BLK_RST;
      dctl_rst_r <= 1'b0;
      dctl_mode_r <= vpe_pkg::MODE_RST;
    end
    else if (rst_done)
    begin
      dctl_en_r <= 1'b0; // [R3]
      dctl_blk_r <= vpe_pkg::BLK_RST; // [R3]
      dctl_mode_r <= vpe_pkg::MODE_RST; // [R3]
      dctl_rst_r <= 1'b0; // [R4]
    end
    else if (wr_dctl)
    begin
      dctl_en_r <= wr_val[vpe_pkg::DCTL_EN_BIT];
      dctl_blk_r <= wr_val[vpe_pkg::DCTL_BLK_BIT];
      // a zero does not cancel a running reset
      dctl_rst_r <= dctl_rst_r || wr_val[vpe_pkg::DCTL_RST_BIT]; // [R1]
      if (!dctl_en_r)
        dctl_mode_r <= wr_val[vpe_pkg::DCTL_MODE_LSB +: vpe_pkg::MODE_W]; // [R5]
    end
  end

  // status flags: set wins over a same-cycle clear
  assign clr = wr_istat ? wd_m[vpe_pkg::NFLAG-1:0] : '0;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      istat_r <= '0;
    else
      istat_r <= (istat_r & ~clr) | flag_set; // [R8] [R12]
  end

  // interrupt enables
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ien_r <= '0;
      gie_r <= 1'b0;
    end
    else if (fire_wr && avs_address == vpe_pkg::OFS_IEN)
    begin
      ien_r <= wr_val[vpe_pkg::NFLAG-1:0];
      gie_r <= wr_val[vpe_pkg::IEN_GIE_BIT];
    end
  end

  // capture thresholds, event counts and modes per channel
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      thr1_r <= {2{vpe_pkg::THR_RST}};
      thr2_r <= {2{vpe_pkg::THR_RST}};
      ct1_r <= {2{vpe_pkg::EVT_RST}};
      ct2_r <= {2{vpe_pkg::EVT_RST}};
      cap_en_r <= '0;
      cap_sep_r <= '0;
    end
    else if (fire_wr)
    begin
      case (avs_address)
        vpe_pkg::OFS_CTHR_A, vpe_pkg::OFS_CTHR_B:
        begin
          thr1_r[avs_address[4]] <= wr_val[vpe_pkg::THR_W-1:0];
          thr2_r[avs_address[4]] <= wr_val[vpe_pkg::HI_LSB +: vpe_pkg::THR_W];
        end
        vpe_pkg::OFS_EVT_A, vpe_pkg::OFS_EVT_B:
        begin
          ct1_r[avs_address[3]] <= wr_val[vpe_pkg::EVT_W-1:0];
          ct2_r[avs_address[3]] <= wr_val[vpe_pkg::HI_LSB +: vpe_pkg::EVT_W];
        end
        vpe_pkg::OFS_CCTL:
        begin
          cap_en_r <= wr_val[1:0];
          cap_sep_r <= wr_val[vpe_pkg::CCTL_SEP_LSB +: 2];
        end
        default: cap_en_r <= cap_en_r;
      endcase
    end
  end

  // ************************************************************
  // display channel reset
  // ************************************************************
  logic vck_s1_r, vck_s2_r, vck_s3_r; // pin synchroniser
  logic vck_edge;
  logic [7:0] edge_cnt_r;

  // two flops before use, third for edge detection
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vck_s1_r <= 1'b0;
      vck_s2_r <= 1'b0;
      vck_s3_r <= 1'b0;
    end
    else
    begin
      vck_s1_r <= channel_input_clock;
      vck_s2_r <= vck_s1_r;
      vck_s3_r <= vck_s2_r;
    end
  end
  assign vck_edge = vck_s2_r && !vck_s3_r;

  // reset waits on channel clock edges, then acts once
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drst_r <= vpe_pkg::DR_IDLE;
      edge_cnt_r <= '0;
    end
    else
    begin
      case (drst_r)
        vpe_pkg::DR_IDLE:
        begin
          edge_cnt_r <= '0;
          if (dctl_rst_r)
            drst_r <= vpe_pkg::DR_WAIT;
        end
        vpe_pkg::DR_WAIT:
        begin
          if (vck_edge)
          begin
            edge_cnt_r <= edge_cnt_r + 1'b1;
            if (edge_cnt_r == 8'(CRST_EDGES - 1))
              drst_r <= vpe_pkg::DR_DONE; // [R1]
          end
        end
        vpe_pkg::DR_DONE: drst_r <= vpe_pkg::DR_IDLE;
        default: drst_r <= vpe_pkg::DR_IDLE;
      endcase
    end
  end

  // display channel controls
  assign disp_fifo_flush = rst_done; // [R3]
  assign display_enable_bit = dctl_en_r;
  assign display_blanking_bit = dctl_blk_r;
  assign disp_mode = dctl_mode_r;
  assign disp_count_run = dctl_en_r && !dctl_rst_r; // [R5]
  assign disp_out_drive = dctl_en_r && !dctl_rst_r; // [R6]
  assign disp_fifo_out_en = dctl_en_r && !dctl_blk_r && !dctl_rst_r; // [R7]
  assign disp_req_allow = dctl_en_r && !dctl_blk_r && !dctl_rst_r; // [R2] [R7]
  assign disp_wr_to_fifo = dctl_en_r && !dctl_rst_r; // [R2]

  // ************************************************************
  // interrupt pulse
  // ************************************************************
  vpe_irq_pulse u_irq (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pending(gie_r && |(istat_r & ien_r)), // [R11]
    .rearm(|(clr & istat_r)), // [R13]
    .irq_pulse(irq_pulse)
  );

  // ************************************************************
  // capture requests: a y cb cr, b y cb cr
  // ************************************************************
  for (genvar g = 0; g < vpe_pkg::NFIFO; g++)
  begin : g_fifo
    localparam int CH = g / 3;
    localparam bit CHROMA = (g % 3) != 0;
    vpe_pkg::vpe_cfg_s cfg;
    logic act;
    // chroma fifos run on half the rounded-up threshold
    always_comb
    begin
      cfg.ct1 = ct1_r[CH];
      cfg.ct2 = ct2_r[CH];
      cfg.thr1 = thr1_r[CH];
      cfg.thr2 = thr2_r[CH];
      if (CHROMA)
      begin
        cfg.thr1 = vpe_pkg::THR_W'(({1'b0, thr1_r[CH]} + thr1_r[CH][0]) >> 1); // [R21]
        cfg.thr2 = vpe_pkg::THR_W'(({1'b0, thr2_r[CH]} + thr2_r[CH][0]) >> 1); // [R21]
      end
    end
    // chroma fifos exist only in the three-fifo modes
    assign act = cap_en_r[CH] && (!CHROMA || cap_sep_r[CH]); // [R20]
    vpe_cap_req #(.LVL_W(LVL_W)) u_req (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .active(act),
      .cfg(cfg),
      .level(cap_fifo_level[g]),
      .dma_rd(cap_dma_rd[g]),
      .req(cap_req[g]), // [R15]
      .outstanding(busy[g])
    );
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_rst_defaults;
    @(posedge ref_clk) disable iff (sys_rst)
      rst_done |=> !dctl_en_r && !dctl_rst_r && dctl_blk_r && disp_mode == vpe_pkg::MODE_RST;
  endproperty
  a_rst_defaults: assert property (p_rst_defaults) else $error("reset left state"); // [R3]
  property p_rst_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      (drst_r == vpe_pkg::DR_WAIT && !vck_edge) |=> dctl_rst_r && !rst_done;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset ended without clock"); // [R4]
  property p_no_req_rst;
    @(posedge ref_clk) disable iff (sys_rst) dctl_rst_r |-> !disp_req_allow;
  endproperty
  a_no_req_rst: assert property (p_no_req_rst) else $error("request during reset"); // [R2]
  property p_blank;
    @(posedge ref_clk) disable iff (sys_rst)
      disp_fifo_out_en |-> !display_blanking_bit && display_enable_bit;
  endproperty
  a_blank: assert property (p_blank) else $error("output while blanked"); // [R7]
  property p_mode_lock;
    @(posedge ref_clk) disable iff (sys_rst)
      (dctl_en_r && !rst_done) |=> $stable(dctl_mode_r);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode changed while enabled"); // [R5]
  property p_w1c;
    @(posedge ref_clk) disable iff (sys_rst)
      (clr & ~flag_set) != '0 |=> (istat_r & $past(clr & ~flag_set)) == '0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared"); // [R12]
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic ref_clk = 0, sys_rst = 1, ch_clk = 0, ch_run = 0, slow = 0, rd = 0, wr = 0;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [11:0] fset = '0;
  logic [5:0][12:0] lvl = '0;
  logic [5:0][11:0] words = '0;
  logic [5:0] dma_rd, creq;
  logic wait_rq, irq, flush, fout, rallow, den, dblk;
  logic [2:0] dlev; // count run, output drive, fifo write levels
  logic [3:0] mode;
  int error_cnt = 0, samples_checked = 0, irq_n = 0, flush_n = 0, req_n[6], t, h;
  int m_stat = 0, m_en = 0, m_glob = 0, m_arm = 1, exp_irq = 0; // interrupt model
  vpe_top i_vpe_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wait_rq), .flag_set(fset), .irq_pulse(irq),
    .cap_fifo_level(lvl), .cap_dma_rd(dma_rd), .cap_req(creq), .channel_input_clock(ch_clk),
    .display_enable_bit(den), .display_blanking_bit(dblk), .disp_mode(mode),
    .disp_fifo_flush(flush), .disp_count_run(dlev[2]), .disp_out_drive(dlev[1]),
    .disp_fifo_out_en(fout), .disp_req_allow(rallow), .disp_wr_to_fifo(dlev[0]));
  vpe_dma_model i_vpe_dma_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(creq),
    .words(words), .slow(slow), .rd(dma_rd));
  initial forever #10 ref_clk = ~ref_clk;
  always #30 if (ch_run) ch_clk <= ~ch_clk;
  // pulse counters, one count per high cycle
  always @(posedge ref_clk)
  begin
    if (irq === 1'b1) irq_n++;
    if (flush === 1'b1) flush_n++;
    for (int i = 0; i < 6; i++) if (creq[i] === 1'b1) req_n[i]++;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    chk(32'(g), 32'(e));
  endtask
  // pulse expected when pending appears while armed
  function automatic void m_eval();
    if (m_glob != 0 && (m_stat & m_en) != 0)
    begin
      if (m_arm != 0) exp_irq++;
      m_arm = 0;
    end
    else m_arm = 1;
  endfunction
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    @(posedge ref_clk);
    while (wait_rq !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) chk(32'h0, 32'h1); // bus hang counts as a mismatch
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (w && a == vpe_pkg::OFS_ISTAT && (m_stat & d) != 0) m_arm = 1;
    if (w && a == vpe_pkg::OFS_ISTAT) m_stat &= ~d;
    if (w && a == vpe_pkg::OFS_IEN) m_en = d[11:0];
    if (w && a == vpe_pkg::OFS_IEN) m_glob = d[16];
    m_eval();
    @(posedge ref_clk);
  endtask
  task automatic flag(input int k);
    fset <= 12'h001 << k;
    @(posedge ref_clk);
    fset <= '0;
    m_stat |= 1 << k;
    m_eval();
    // idle edge so a following call never re-drives fset in this step
    @(posedge ref_clk);
  endtask
  task automatic chk_irq();
    repeat (6) @(posedge ref_clk);
    chk_n(irq_n, exp_irq);
  endtask
  // poll status until nothing outstanding and display reset idle
  task automatic drain();
    bus(0, vpe_pkg::OFS_RSTAT, 0);
    for (int n = 0; n < 40 && q[8:0] !== 9'h0; n++) bus(0, vpe_pkg::OFS_RSTAT, 0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    chk(32'h0, 32'h1); // watchdog ran out
    conclude();
  end
  initial
  begin
    void'($urandom(32'h79dadabc));
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    bus(0, vpe_pkg::OFS_CTHR_A, 0);
    chk(q, 32'h0001_0001);
    bus(1, 8'h40, 32'hFFFF_FFFF);
    bus(0, 8'h40, 0);
    chk(q, 32'h0);
    // each source alone under its own enable
    for (int k = 0; k < 12; k++)
    begin
      bus(1, vpe_pkg::OFS_IEN, 32'h0001_0000 | (32'h1 << k));
      flag(k);
      chk_irq();
      bus(1, vpe_pkg::OFS_ISTAT, 32'h1 << k);
    end
    bus(1, vpe_pkg::OFS_IEN, 32'h0001_0003);
    flag(0);
    flag(1);
    chk_irq();
    bus(0, vpe_pkg::OFS_ISTAT, 0);
    chk(q, 32'h3);
    bus(1, vpe_pkg::OFS_ISTAT, 32'h1);
    chk_irq();
    bus(1, vpe_pkg::OFS_ISTAT, 32'h2);
    flag(2);
    chk_irq();
    bus(0, vpe_pkg::OFS_ISTAT, 0);
    chk(q, 32'h4);
    bus(1, vpe_pkg::OFS_ISTAT, 32'h4);
    bus(1, vpe_pkg::OFS_IEN, 32'h3);
    flag(0);
    bus(1, vpe_pkg::OFS_IEN, 32'h0001_0003);
    chk_irq();
    bus(1, vpe_pkg::OFS_ISTAT, 32'h1);
    $display("test interrupts done");
    bus(1, vpe_pkg::OFS_DCTL, 32'h1);
    chk({31'b0, fout}, 32'h1);
    chk({27'b0, den, dblk, dlev}, 32'h17);
    bus(1, vpe_pkg::OFS_DCTL, 32'hF1);
    chk({28'b0, mode}, 32'h0);
    bus(1, vpe_pkg::OFS_DCTL, 32'h5);
    repeat (20) @(posedge ref_clk);
    bus(1, vpe_pkg::OFS_ISTAT, 32'h0);
    bus(0, vpe_pkg::OFS_RSTAT, 0);
    chk({23'b0, q[8:0]}, 32'h100);
    chk({31'b0, rallow}, 32'h0);
    chk({29'b0, dlev}, 32'h0);
    ch_run <= 1'b1;
    drain();
    ch_run <= 1'b0;
    chk(q, 32'h0);
    bus(0, vpe_pkg::OFS_DCTL, 0);
    chk(q, 32'h2);
    chk({27'b0, den, dblk, dlev}, 32'h8);
    chk_n(flush_n, 1);
    $display("test display reset done");
    t = 2 + $urandom % 7;
    h = (t + t % 2) / 2;
    words <= {12'(h), 12'(h), 12'(t), 12'(h), 12'(h), 12'(t)};
    bus(1, vpe_pkg::OFS_CTHR_A, 32'(t << 16 | t));
    bus(1, vpe_pkg::OFS_CCTL, 32'h5);
    lvl <= {13'h1FFF, 13'h1FFF, 13'h1FFF, 13'(h), 13'(h - 1), 13'(t)};
    repeat (3) @(posedge ref_clk);
    lvl <= '0;
    drain();
    chk(q, 32'h0);
    chk_n(req_n[0], 1);
    chk_n(req_n[1], 0);
    chk_n(req_n[2], 1);
    chk_n(req_n[3] + req_n[4] + req_n[5], 0);
    slow <= 1'b1;
    lvl[0] <= 13'(2 * t + 1);
    for (int n = 0; n < 40 && req_n[0] < 3; n++) @(posedge ref_clk);
    lvl <= '0;
    drain();
    chk_n(req_n[0], 3);
    chk(q, 32'h0);
    $display("test capture requests done");
    conclude();
  end
endmodule

// ==== test/vpe_dma_model.sv ====
`timescale 1ns/1ps
// ************************************************************
// dma controller stand-in: services each fifo after its request
// ************************************************************
module vpe_dma_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [5:0] req,
  input wire logic [5:0][11:0] words,
  input wire logic slow,
  output logic [5:0] rd
);
  int dly_r[6]; // cycles before the first read
  int left_r[6]; // doublewords still owed, requests queue up
  // one read pulse per cycle once service starts
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      rd <= '0;
      dly_r <= '{default: 0};
      left_r <= '{default: 0};
    end
    else
      for (int i = 0; i < 6; i++)
      begin
        rd[i] <= 1'b0;
        if (req[i])
        begin
          left_r[i] <= left_r[i] + int'(words[i]);
          if (left_r[i] == 0)
            dly_r[i] <= slow ? 6 : 1; // slow or prompt answer
        end
        else if (dly_r[i] > 1)
          dly_r[i] <= dly_r[i] - 1;
        else if (left_r[i] > 0)
        begin
          rd[i] <= 1'b1; // first read starts service
          left_r[i] <= left_r[i] - 1;
        end
      end
endmodule
